// ---- design/config_pins.sv ----
// Configuration control pins: restart, mode latch, clock role, done, tristate, readback
// Notes on behaviour
// - User pins float with pull-up while configuring
// - Unused pins float with pull-up afterwards
// - Reset during configuration restarts the load
// - Reset pin later user input or set/reset
// - Master and async peripheral drive config clock
// - Microprocessor mode drives clock for daisy chain
// - External low on done delays start-up
// - Done released high only when complete
// - Program low restarts and resets boundary scan
// - Trigger low while configuring tristates all pins
// - After config trigger: tristate or readback start
// - Shared pin carries readback or scan data
// - Mode pins latched on init rising edge
// - Mode pins become user pins afterwards
// - Init low while clearing; external low waits
`timescale 1ns/100ps
module config_pins (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        link_clk,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        reset_pin,
    input  wire logic        program_restart_n,
    input  wire logic        done_in,
    output logic             done_out,
    output logic             done_oe,
    input  wire logic        init_n_in,
    output logic             init_n_out,
    output logic             init_n_oe,
    input  wire logic        readback_trigger_n,
    input  wire logic [2:0]  config_mode_select,
    output logic             config_clock_out,
    output logic             config_clock_oe,
    input  wire logic        tdo,
    output logic             shared_out,
    output logic             shared_oe,
    output logic             user_io_oe_allow,
    output logic             user_io_pullup,
    output logic             unused_pin_pullup,
    output logic             mode_pins_user,
    output logic             global_tristate,
    output logic             scan_reset,
    output logic             cell_set_reset,
    output logic             user_reset
);
    import config_pins_pkg::*;

    // Pin synchronisers: only stage [1] is read
    logic [1:0] reset_sync, prog_sync, done_sync, init_sync, trig_sync, ack_sync;
    logic [2:0] mode_sync0, mode_sync1;
    logic       init_d, trig_d, rb_ack;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_sync <= 2'h0;
            prog_sync  <= 2'h3;
            done_sync  <= 2'h0;
            init_sync  <= 2'h0;
            trig_sync  <= 2'h3;
            ack_sync   <= 2'h0;
            mode_sync0 <= MODE_RESET;
            mode_sync1 <= MODE_RESET;
            init_d     <= 1'b0;
            trig_d     <= 1'b1;
        end else begin
            reset_sync <= {reset_sync[0], reset_pin};
            prog_sync  <= {prog_sync[0], program_restart_n};
            done_sync  <= {done_sync[0], done_in};
            init_sync  <= {init_sync[0], init_n_in};
            trig_sync  <= {trig_sync[0], readback_trigger_n};
            ack_sync   <= {ack_sync[0], rb_ack};
            mode_sync0 <= config_mode_select;
            mode_sync1 <= mode_sync0;
            init_d     <= init_sync[1];
            trig_d     <= trig_sync[1];
        end
    end

    logic reset_s, prog_s, done_s, init_s, trig_s, ack_s;
    assign reset_s = reset_sync[1];
    assign prog_s  = prog_sync[1];
    assign done_s  = done_sync[1];
    assign init_s  = init_sync[1];
    assign trig_s  = trig_sync[1];
    assign ack_s   = ack_sync[1];

    // Register bus
    logic [7:0]  control, next_control;
    logic [31:0] rb_data, next_rb_data, next_readdata;
    logic        next_waitrequest, access, wr_fire, load_done;
    logic        rb_busy, rb_req;
    logic [7:0]  frame_address;
    cfg_state_type state, next_state;
    logic [2:0]  mode, next_mode;

    always_comb begin
        access           = (read || write) && waitrequest;
        wr_fire          = write && !waitrequest;
        next_waitrequest = !access;
        next_readdata    = readdata;
        next_control     = control;
        next_rb_data     = rb_data;
        load_done        = 1'b0;
        if (access && read) begin
            case (address)
                CONTROL_OFFSET:       next_readdata = {24'h0, control};
                STATUS_OFFSET:        next_readdata = {15'h0, frame_address, rb_busy, done_s,
                                                       init_s, mode, state};
                READBACK_DATA_OFFSET: next_readdata = rb_data;
                default:              next_readdata = 32'h0000_0000;
            endcase
        end
        if (wr_fire && address == CONTROL_OFFSET && byteenable[0]) begin
            next_control = writedata[7:0] & CONTROL_MASK;
            load_done    = writedata[CTRL_LOAD_DONE];
        end
        // Frame word must hold still while the link side may be copying it
        if (wr_fire && address == READBACK_DATA_OFFSET && !rb_busy) begin
            for (int b = 0; b < 4; b++) begin
                if (byteenable[b]) begin
                    next_rb_data[8*b +: 8] = writedata[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
            control     <= CONTROL_RESET;
            rb_data     <= READBACK_DATA_RESET;
        end else begin
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
            control     <= next_control;
            rb_data     <= next_rb_data;
        end
    end

    // Configuration sequence
    logic [7:0] clear_cnt, next_clear_cnt;
    logic       config_busy;

    always_comb begin
        next_state     = state;
        next_clear_cnt = clear_cnt;
        next_mode      = mode;
        config_busy    = (state != ST_USER);
        case (state)
            ST_CLEAR: begin
                if (clear_cnt == CLEAR_LAST) begin
                    next_state = ST_WAIT;
                end else begin
                    next_clear_cnt = clear_cnt + 8'h01;
                end
            end
            ST_WAIT: begin
                if (init_s && !init_d) begin
                    next_mode  = mode_sync1;
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (load_done) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (done_s) begin
                    next_state = ST_USER;
                end
            end
            ST_USER: next_state = ST_USER;
            default: next_state = ST_CLEAR;
        endcase
        if (!prog_s || (reset_s && config_busy)) begin
            next_state     = ST_CLEAR;
            next_clear_cnt = 8'h00;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= ST_CLEAR;
            clear_cnt <= 8'h00;
            mode      <= MODE_RESET;
        end else begin
            state     <= next_state;
            clear_cnt <= next_clear_cnt;
            mode      <= next_mode;
        end
    end

    // Pin roles and clock generation
    logic       ts_cond, next_config_clock;
    logic [1:0] div_cnt, next_div_cnt;

    always_comb begin
        ts_cond      = !trig_s && (config_busy || control[CTRL_TRIGGER_TRISTATE]);
        next_div_cnt = div_cnt + 2'h1;
        next_config_clock    = config_clock_out;
        if (div_cnt == CLOCK_HALF_LAST) begin
            next_div_cnt = 2'h0;
            next_config_clock    = !config_clock_out;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt           <= 2'h0;
            config_clock_out  <= 1'b0;
            config_clock_oe   <= 1'b0;
            done_out          <= 1'b0;
            done_oe           <= 1'b1;
            init_n_out        <= 1'b0;
            init_n_oe         <= 1'b1;
            user_io_oe_allow  <= 1'b0;
            user_io_pullup    <= 1'b1;
            unused_pin_pullup <= 1'b1;
            mode_pins_user    <= 1'b0;
            global_tristate   <= 1'b0;
            scan_reset        <= 1'b0;
            cell_set_reset    <= 1'b0;
            user_reset        <= 1'b0;
        end else begin
            div_cnt           <= next_div_cnt;
            config_clock_out  <= next_config_clock;
            // Slave modes leave the pin to the host
            config_clock_oe   <= (state == ST_LOAD) && drives_clock(mode);
            done_out          <= 1'b0;
            done_oe           <= (state == ST_CLEAR) || (state == ST_WAIT) ||
                                 (state == ST_LOAD);
            init_n_out        <= 1'b0;
            init_n_oe         <= (state == ST_CLEAR);
            user_io_oe_allow  <= !config_busy && !ts_cond;
            user_io_pullup    <= config_busy;
            unused_pin_pullup <= 1'b1;
            mode_pins_user    <= !config_busy;
            global_tristate   <= ts_cond;
            scan_reset        <= !prog_s;
            cell_set_reset    <= !config_busy && control[CTRL_RESET_SET_RESET] && reset_s;
            user_reset        <= !config_busy && reset_s;
        end
    end

    // Readback control: toggle request, toggle acknowledge
    logic       next_rb_busy, next_rb_req, ack_d, rb_fall;
    logic [7:0] next_frame_address;

    always_comb begin
        next_rb_busy       = rb_busy;
        next_rb_req        = rb_req;
        next_frame_address = frame_address;
        // Trigger edges before user mode are ignored; a low then tristates the pins instead
        rb_fall = trig_d && !trig_s && (state == ST_USER);
        if (!rb_busy && rb_fall && control[CTRL_READBACK_ENABLE] &&
            !control[CTRL_TRIGGER_TRISTATE]) begin
            next_rb_busy       = 1'b1;
            next_frame_address = 8'h00;
            next_rb_req        = !rb_req;
        end else if (rb_busy && ack_s != ack_d) begin
            if (frame_address == FRAME_LAST) begin
                next_rb_busy = 1'b0;
            end else begin
                next_frame_address = frame_address + 8'h01;
                next_rb_req        = !rb_req;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rb_busy       <= 1'b0;
            rb_req        <= 1'b0;
            ack_d         <= 1'b0;
            frame_address <= 8'h00;
        end else begin
            rb_busy       <= next_rb_busy;
            rb_req        <= next_rb_req;
            ack_d         <= ack_s;
            frame_address <= next_frame_address;
        end
    end

    // Link side: serialises one frame word per request
    logic [1:0]  req_sync, scan_sync;
    logic        req_d, sending, next_sending, next_ack, next_shared_out, next_shared_oe;
    logic [4:0]  bit_cnt, next_bit_cnt;
    logic [31:0] shreg, next_shreg;

    always_comb begin
        next_sending = sending;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_ack     = rb_ack;
        if (req_sync[1] != req_d) begin
            next_shreg   = {frame_address, rb_data[23:0]};
            next_sending = 1'b1;
            next_bit_cnt = 5'h00;
        end else if (sending) begin
            next_shreg   = {shreg[30:0], 1'b0};
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt == WORD_BIT_LAST) begin
                next_sending = 1'b0;
                next_ack     = !rb_ack;
            end
        end
        next_shared_out = scan_sync[1] ? tdo : shreg[31];
        next_shared_oe  = scan_sync[1] || sending;
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            req_sync   <= 2'h0;
            scan_sync  <= 2'h0;
            req_d      <= 1'b0;
            sending    <= 1'b0;
            bit_cnt    <= 5'h00;
            shreg      <= 32'h0000_0000;
            rb_ack     <= 1'b0;
            shared_out <= 1'b0;
            shared_oe  <= 1'b0;
        end else begin
            req_sync   <= {req_sync[0], rb_req};
            scan_sync  <= {scan_sync[0], control[CTRL_SCAN_PIN]};
            req_d      <= req_sync[1];
            sending    <= next_sending;
            bit_cnt    <= next_bit_cnt;
            shreg      <= next_shreg;
            rb_ack     <= next_ack;
            shared_out <= next_shared_out;
            shared_oe  <= next_shared_oe;
        end
    end

    a_io_hiz_config: assert property (@(posedge clk) disable iff (rst)
        config_busy |=> (!user_io_oe_allow && user_io_pullup))
        else $error("user pins not floating during configuration");
    a_unused_pullup: assert property (@(posedge clk) disable iff (rst)
        !config_busy |=> unused_pin_pullup)
        else $error("unused pin pull-up dropped");
    a_reset_restart: assert property (@(posedge clk) disable iff (rst)
        (reset_s && config_busy) |=> (state == ST_CLEAR && clear_cnt == 8'h00))
        else $error("reset did not restart configuration");
    a_set_reset_use: assert property (@(posedge clk) disable iff (rst)
        (!config_busy && reset_s && control[CTRL_RESET_SET_RESET]) |=> cell_set_reset)
        else $error("cell set/reset not driven");
    a_clock_drive: assert property (@(posedge clk) disable iff (rst)
        (state == ST_LOAD) |=> (config_clock_oe == drives_clock($past(mode))))
        else $error("config clock direction wrong for mode");
    a_hold_on_done: assert property (@(posedge clk) disable iff (rst)
        (state == ST_HOLD && !done_s && prog_s && !reset_s) |=> (state == ST_HOLD))
        else $error("start-up not delayed by low done");
    a_done_low: assert property (@(posedge clk) disable iff (rst)
        (state == ST_LOAD) |=> (done_oe && !done_out))
        else $error("done released before completion");
    a_prog_restart: assert property (@(posedge clk) disable iff (rst)
        !prog_s |=> (state == ST_CLEAR && scan_reset))
        else $error("program low did not restart and reset scan");
    a_tristate_cfg: assert property (@(posedge clk) disable iff (rst)
        (!trig_s && config_busy) |=> (global_tristate && !user_io_oe_allow))
        else $error("trigger low did not tristate pins");
    a_readback_start: assert property (@(posedge clk) disable iff (rst)
        (!rb_busy && rb_fall && control[CTRL_READBACK_ENABLE] &&
         !control[CTRL_TRIGGER_TRISTATE]) |=> (rb_busy && frame_address == 8'h00 &&
         rb_req != $past(rb_req)))
        else $error("readback did not start at frame zero");
    a_shared_scan: assert property (@(posedge link_clk) disable iff (rst)
        scan_sync[1] |=> (shared_oe && shared_out == $past(tdo)))
        else $error("shared pin not carrying scan data");
    a_mode_latch: assert property (@(posedge clk) disable iff (rst)
        (state == ST_WAIT && init_s && !init_d && prog_s && !reset_s) |=>
        (mode == $past(mode_sync1) && state == ST_LOAD))
        else $error("mode not latched on init rise");
    a_init_clear: assert property (@(posedge clk) disable iff (rst)
        (state == ST_CLEAR) |=> (init_n_oe && !init_n_out))
        else $error("init not driven low while clearing");
endmodule : config_pins

// ---- design/config_pins_pkg.sv ----
// Shared constants, register map and types of the configuration pin controller
package config_pins_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLEAR_TIME_NS = 1000;
    localparam int CLEAR_CYCLES  = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CLEAR_LAST = 8'(CLEAR_CYCLES - 1);
    localparam logic [1:0] CLOCK_HALF_LAST = 2'h1;

    localparam logic [3:0] CONTROL_OFFSET       = 4'h0;
    localparam logic [3:0] STATUS_OFFSET        = 4'h4;
    localparam logic [3:0] READBACK_DATA_OFFSET = 4'h8;

    localparam int CTRL_LOAD_DONE        = 0;
    localparam int CTRL_READBACK_ENABLE  = 1;
    localparam int CTRL_TRIGGER_TRISTATE = 2;
    localparam int CTRL_RESET_SET_RESET  = 3;
    localparam int CTRL_SCAN_PIN         = 4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_MASK  = 8'h1e;
    localparam logic [31:0] READBACK_DATA_RESET = 32'h0000_0000;

    localparam logic [7:0] FRAME_LAST    = 8'h03;
    localparam logic [4:0] WORD_BIT_LAST = 5'h1f;

    localparam logic [2:0] MODE_MASTER_SERIAL   = 3'h0;
    localparam logic [2:0] MODE_MASTER_PARALLEL = 3'h1;
    localparam logic [2:0] MODE_ASYNC_PERIPH    = 3'h2;
    localparam logic [2:0] MODE_SYNC_PERIPH     = 3'h3;
    localparam logic [2:0] MODE_MICROPROCESSOR  = 3'h4;
    localparam logic [2:0] MODE_SLAVE_PARALLEL  = 3'h6;
    localparam logic [2:0] MODE_SLAVE_SERIAL    = 3'h7;
    localparam logic [2:0] MODE_RESET           = 3'h7;

    typedef enum logic [2:0] {ST_CLEAR, ST_WAIT, ST_LOAD, ST_HOLD, ST_USER} cfg_state_type;

    function automatic logic drives_clock(input logic [2:0] mode);
        drives_clock = (mode == MODE_MASTER_SERIAL) || (mode == MODE_MASTER_PARALLEL) ||
                       (mode == MODE_ASYNC_PERIPH) || (mode == MODE_MICROPROCESSOR);
    endfunction : drives_clock
endpackage : config_pins_pkg

// ---- verif/config_host_model.sv ----
// Configuration host model: open-drain init and done wires, scan data, readback receiver
`timescale 1ns/100ps
module config_host_model (
    input  wire logic link_clk,
    input  wire logic init_hold,
    input  wire logic done_hold,
    input  wire logic init_n_oe,
    input  wire logic done_oe,
    input  wire logic capture,
    input  wire logic shared_out,
    input  wire logic shared_oe,
    output logic      init_wire,
    output logic      done_wire,
    output logic      tdo
);
    logic [31:0] shift = 32'h0;
    logic [31:0] words [0:7];
    int          nbits = 0;
    int          nwords = 0;
    // Both wires have pull-ups; any party pulling low wins
    assign init_wire = !(init_n_oe || init_hold);
    assign done_wire = !(done_oe || done_hold);
    // Scan data changes every link cycle so a stale pin value cannot pass; one driver only
    always @(posedge link_clk) begin
        tdo <= (tdo !== 1'b1);
    end
    // Sample mid-bit, away from the edge that launches each bit
    always @(negedge link_clk) begin
        if (capture && shared_oe) begin
            shift = {shift[30:0], shared_out};
            nbits++;
            if (nbits == 32) begin
                words[nwords[2:0]] = shift;
                nwords++;
                nbits = 0;
            end
        end
    end
endmodule : config_host_model

// ---- verif/fpga_config_control_pins_tb.sv ----
// Self-checking bench of the configuration control pins
`timescale 1ns/100ps
module fpga_config_control_pins_tb;
    import config_pins_pkg::*;
    typedef struct packed {
        logic [2:0] mode;
        logic       clk_oe;
    } row_type;
    logic        clk, rst, link_clk, read, write, waitrequest, reset_pin, program_restart_n;
    logic        done_out, done_oe, init_n_out, init_n_oe, readback_trigger_n, tdo;
    logic        config_clock_out, config_clock_oe, shared_out, shared_oe, user_io_oe_allow;
    logic        user_io_pullup, unused_pin_pullup, mode_pins_user, global_tristate;
    logic        scan_reset, cell_set_reset, user_reset, init_wire, done_wire;
    logic        init_hold, done_hold, capture;
    logic [3:0]  address, byteenable;
    logic [2:0]  config_mode_select;
    logic [31:0] writedata, readdata, q;
    int          mismatches, n_tests;
    row_type     rows [0:6] = '{'{MODE_MASTER_SERIAL, 1'b1}, '{MODE_MASTER_PARALLEL, 1'b1},
        '{MODE_ASYNC_PERIPH, 1'b1}, '{MODE_SYNC_PERIPH, 1'b0}, '{MODE_MICROPROCESSOR, 1'b1},
        '{MODE_SLAVE_PARALLEL, 1'b0}, '{MODE_SLAVE_SERIAL, 1'b0}};

    config_pins u_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .reset_pin(reset_pin),
        .program_restart_n(program_restart_n), .done_in(done_wire), .done_out(done_out),
        .done_oe(done_oe), .init_n_in(init_wire), .init_n_out(init_n_out),
        .init_n_oe(init_n_oe), .readback_trigger_n(readback_trigger_n),
        .config_mode_select(config_mode_select), .config_clock_out(config_clock_out),
        .config_clock_oe(config_clock_oe), .tdo(tdo), .shared_out(shared_out),
        .shared_oe(shared_oe), .user_io_oe_allow(user_io_oe_allow),
        .user_io_pullup(user_io_pullup), .unused_pin_pullup(unused_pin_pullup),
        .mode_pins_user(mode_pins_user), .global_tristate(global_tristate),
        .scan_reset(scan_reset), .cell_set_reset(cell_set_reset), .user_reset(user_reset));
    config_host_model u_host (.link_clk(link_clk), .init_hold(init_hold),
        .done_hold(done_hold), .init_n_oe(init_n_oe), .done_oe(done_oe), .capture(capture),
        .shared_out(shared_out), .shared_oe(shared_oe), .init_wire(init_wire),
        .done_wire(done_wire), .tdo(tdo));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // First rising edge lands inside reset so the link flops start from known values
    initial begin
        link_clk = 1'b0;
        #20;
        forever begin
            link_clk = ~link_clk;
            #40;
        end
    end
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        #2000000;
        mismatches++;
        end_sim();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= 4'hf;
        write <= wr;
        read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            chk(waitrequest, 32'h0);
            end_sim();
        end
    endtask : bus
    // One full load: restart, wait state, mode latch, load, held start-up, user mode
    task automatic config_run(input row_type r);
        @(posedge clk);
        program_restart_n <= 1'b0;
        init_hold <= 1'b1;
        config_mode_select <= r.mode;
        cyc(4);
        @(negedge clk);
        chk(scan_reset, 32'h1);
        @(posedge clk);
        program_restart_n <= 1'b1;
        cyc(50);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[2:0], 32'h1);
        @(negedge clk);
        chk(init_n_oe, 32'h0);
        chk(user_io_pullup, 32'h1);
        @(posedge clk);
        init_hold <= 1'b0;
        cyc(8);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[5:0], {r.mode, 3'h2});
        @(negedge clk);
        chk(config_clock_oe, r.clk_oe);
        chk({done_oe, user_io_oe_allow}, 32'h2);
        chk(mode_pins_user, 32'h0);
        // Clock output runs at a quarter of clk: one toggle in any two cycles
        q[0] = config_clock_out;
        cyc(2);
        @(negedge clk);
        chk(config_clock_out, !q[0]);
        @(posedge clk);
        config_mode_select <= ~r.mode;
        done_hold <= 1'b1;
        bus(1'b1, CONTROL_OFFSET, 32'h1);
        cyc(10);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[5:0], {r.mode, 3'h3});
        chk(done_oe, 32'h0);
        done_hold <= 1'b0;
        cyc(8);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[2:0], 32'h4);
        @(negedge clk);
        chk({mode_pins_user, user_io_oe_allow, unused_pin_pullup}, 32'h7);
    endtask : config_run

    initial begin
        {rst, read, write, reset_pin, init_hold, done_hold, capture} = 7'h40;
        {address, byteenable, writedata} = 40'h0;
        program_restart_n = 1'b1;
        readback_trigger_n = 1'b1;
        config_mode_select = 3'h0;
        mismatches = 0;
        n_tests = 0;
        cyc(2);
        rst <= 1'b0;
        @(negedge clk);
        chk({waitrequest, done_oe, init_n_oe, config_clock_oe}, 32'he);
        chk({user_io_pullup, user_io_oe_allow, unused_pin_pullup}, 32'h5);
        bus(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, CONTROL_OFFSET, 32'h0);
        chk(q, 32'(CONTROL_RESET));
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            config_run(rows[i]);
            $display("test mode %0d done", rows[i].mode);
        end
        bus(1'b1, CONTROL_OFFSET, 32'h8);
        reset_pin <= 1'b1;
        cyc(6);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk({q[2:0], cell_set_reset, user_reset}, 32'h13);
        reset_pin <= 1'b0;
        bus(1'b1, CONTROL_OFFSET, 32'h4);
        readback_trigger_n <= 1'b0;
        cyc(6);
        @(negedge clk);
        chk(global_tristate, 32'h1);
        @(posedge clk);
        readback_trigger_n <= 1'b1;
        bus(1'b1, CONTROL_OFFSET, 32'h10);
        cyc(10);
        chk(shared_oe, 32'h1);
        $display("test user pins done");
        bus(1'b1, READBACK_DATA_OFFSET, 32'h00abcdef);
        bus(1'b1, CONTROL_OFFSET, 32'h2);
        cyc(10);
        capture <= 1'b1;
        readback_trigger_n <= 1'b0;
        cyc(4);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[16:8], 32'h1);
        readback_trigger_n <= 1'b1;
        for (int n = 0; n < 3000 && u_host.nwords < 4; n++) begin
            cyc(1);
        end
        for (int i = 0; i < 4; i++) begin
            chk(u_host.words[i], {i[7:0], 24'habcdef});
        end
        cyc(10);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[8], 32'h0);
        $display("test readback done");
        program_restart_n <= 1'b0;
        cyc(4);
        program_restart_n <= 1'b1;
        cyc(60);
        readback_trigger_n <= 1'b0;
        cyc(6);
        @(negedge clk);
        chk(global_tristate, 32'h1);
        @(posedge clk);
        readback_trigger_n <= 1'b1;
        reset_pin <= 1'b1;
        cyc(6);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[2:0], 32'h0);
        reset_pin <= 1'b0;
        $display("test restart done");
        end_sim();
    end
endmodule : fpga_config_control_pins_tb
